/* File: core/spl_core.sv */
// Servo position parameter logic with AXI4-Lite registers
// Function
// - Gear ratio 1/9999..9999, den*stations<=32767, num*den<=100000.
// - Any gear violation raises parameter fault alarm, code 37h.
// - Gear numerator and denominator accept 1 through 16384.
// - Gear, station and encoder settings take effect only at restart.
// - Command pulses scaled by numerator over denominator.
// - Gain selector: 0 interp, 1 auto one, 2 auto two, 3 manual.
// - Interp, auto one and auto two each update their own set of loop gains; manual updates none.
// - Within window, both completion and in-window outputs asserted.
// - Forward clamp limits CCW driving and CW regeneration torque.
// - Reverse clamp limits CW driving and CCW regeneration torque.
// - Clamp of zero gives no torque in its directions.
// - One bit selects station numbering direction, default 0.
// - Encoder setting accepts 1 to 65535, reset 4000.
// - Emitted A/B pulses per rev are a quarter of the count.
// - Mode 0: setting is output count per revolution.
// - Mode 1: resolution divided by setting gives output count.
// - Absolute select: 0 incremental, 1 absolute detection.
`timescale 1ns/100ps
`include "spl_params.svh"
module spl_core (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [7:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    input wire logic i_cmd_pulse,
    input wire logic i_cmd_dir,
    input wire logic i_enc_step,
    input wire logic i_enc_dir,
    input wire logic [31:0] i_pos_err,
    input wire logic [15:0] i_torque_cmd,
    output logic o_motor_step,
    output logic o_motor_dir,
    output logic o_enc_a,
    output logic o_enc_b,
    output logic o_move_complete_output,
    output logic o_in_window_output,
    output logic [15:0] o_torque_out,
    output logic [4:0] o_gain_update_mask,
    output logic [5:0] o_tuning_response,
    output logic o_station_order,
    output logic o_absolute_position_select,
    output logic o_parameter_fault_alarm
);
    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] resp;
        logic [15:0] window;
        logic [15:0] fwd;
        logic [15:0] rev;
        logic [15:0] station;
        logic [15:0] enc;
        logic [15:0] num;
        logic [15:0] den;
        logic [15:0] station_count;
        logic [1:0] ctrl;
        logic restart;
        spl_pkg::spl_cfg_type act;
        logic fault;
        logic [2:0] cmd_sync;
        logic [1:0] cdir_sync;
        logic [2:0] enc_sync;
        logic [1:0] edir_sync;
        logic [31:0] acc;
        logic mstep;
        logic mdir;
        logic inwin;
        logic [15:0] torque;
        logic [4:0] gmask;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } spl_core_state_type;

    spl_core_state_type st_reg;
    spl_core_state_type st_next;
    spl_enc_if enc_if ();

    logic [31:0] num32;
    logic [31:0] den32;
    logic gear_bad;
    logic cmd_edge;
    logic steps_due;
    logic [31:0] err_abs;
    logic [16:0] tq_cmd;
    logic [16:0] tq_fwd;
    logic [16:0] tq_rev;

    function automatic logic [15:0] wr16(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_comb begin
        st_next = st_reg;
        num32 = {16'h0000, st_reg.act.num};
        den32 = {16'h0000, st_reg.act.den};
        gear_bad = (st_reg.act.num == 16'h0000)
            || (st_reg.act.num > `SPL_GEAR_MAX)
            || (st_reg.act.den == 16'h0000)
            || (st_reg.act.den > `SPL_GEAR_MAX);
        gear_bad = gear_bad || (num32 * `SPL_RATIO_MAX < den32)
            || (num32 > den32 * `SPL_RATIO_MAX)
            || (den32 * {16'h0000, st_reg.act.station_count} > `SPL_DEN_STN_MAX)
            || (num32 * den32 > `SPL_NUM_DEN_MAX);
        gear_bad = gear_bad || (st_reg.act.enc == 16'h0000);
        st_next.fault = gear_bad;

        st_next.cmd_sync = {st_reg.cmd_sync[1:0], i_cmd_pulse};
        st_next.cdir_sync = {st_reg.cdir_sync[0], i_cmd_dir};
        st_next.enc_sync = {st_reg.enc_sync[1:0], i_enc_step};
        st_next.edir_sync = {st_reg.edir_sync[0], i_enc_dir};
        cmd_edge = st_reg.cmd_sync[1] && !st_reg.cmd_sync[2];

        st_next.restart = 1'b0;
        if (st_reg.restart) begin
            st_next.act.num = st_reg.num;
            st_next.act.den = st_reg.den;
            st_next.act.station_count = st_reg.station_count;
            st_next.act.enc = st_reg.enc;
            st_next.act.station = st_reg.station[0];
            st_next.act.enc_mode = st_reg.ctrl[`SPL_CTRL_ENC_MODE];
            st_next.act.abs_sel = st_reg.ctrl[`SPL_CTRL_ABS];
        end

        steps_due = !st_reg.fault && (st_reg.acc >= den32);
        st_next.mstep = steps_due;
        st_next.acc = st_reg.acc + ((cmd_edge && !st_reg.fault) ? num32
            : 32'h00000000) - (steps_due ? den32 : 32'h00000000);
        if (st_reg.fault) begin
            st_next.acc = 32'h00000000;
        end
        if (cmd_edge) begin
            st_next.mdir = st_reg.cdir_sync[1];
        end

        err_abs = i_pos_err[31] ? 32'h00000000 - i_pos_err : i_pos_err;
        st_next.inwin = err_abs <= {16'h0000, st_reg.window};
        tq_cmd = {i_torque_cmd[15], i_torque_cmd};
        tq_fwd = {1'b0, st_reg.fwd};
        tq_rev = 17'h00000 - {1'b0, st_reg.rev};
        st_next.torque = i_torque_cmd;
        if ($signed(tq_cmd) > $signed(tq_fwd)) begin
            st_next.torque = st_reg.fwd;
        end else if ($signed(tq_cmd) < $signed(tq_rev)) begin
            st_next.torque = tq_rev[15:0];
        end

        st_next.gmask = 5'h00;
        if (st_reg.gain[15:2] == 14'h0000) begin
            case (spl_pkg::spl_gain_type'(st_reg.gain[1:0]))
                spl_pkg::GAIN_INTERP: st_next.gmask = 5'h1D;
                spl_pkg::GAIN_AUTO1: st_next.gmask = 5'h1F;
                spl_pkg::GAIN_AUTO2: st_next.gmask = 5'h1E;
                default: st_next.gmask = 5'h00;
            endcase
        end

        if (i_s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
            st_next.w_got = 1'b1;
            st_next.wdata = i_s_axi_wdata;
            st_next.wstrb = i_s_axi_wstrb;
        end
        if (st_reg.bvalid && i_s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `SPL_RESP_OKAY;
            case (st_reg.awaddr)
                `SPL_OFS_GAIN: st_next.gain =
                    wr16(st_reg.gain, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_RESP: st_next.resp =
                    wr16(st_reg.resp, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_WINDOW: st_next.window =
                    wr16(st_reg.window, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_FWD: st_next.fwd =
                    wr16(st_reg.fwd, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_REV: st_next.rev =
                    wr16(st_reg.rev, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_STATION: st_next.station =
                    wr16(st_reg.station, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_ENC: st_next.enc =
                    wr16(st_reg.enc, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_NUM: st_next.num =
                    wr16(st_reg.num, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_DEN: st_next.den =
                    wr16(st_reg.den, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_STN: st_next.station_count =
                    wr16(st_reg.station_count, st_reg.wdata, st_reg.wstrb);
                `SPL_OFS_CTRL: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.ctrl = st_reg.wdata[1:0];
                    end
                    if (st_reg.wstrb[1]) begin
                        st_next.restart = st_reg.wdata[`SPL_CTRL_RESTART];
                    end
                end
                `SPL_OFS_STATUS: st_next.bresp = `SPL_RESP_OKAY;
                default: st_next.bresp = `SPL_RESP_DECERR;
            endcase
        end

        if (st_reg.rvalid && i_s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `SPL_RESP_OKAY;
            st_next.rdata = 32'h00000000;
            case (i_s_axi_araddr)
                `SPL_OFS_GAIN: st_next.rdata[15:0] = st_reg.gain;
                `SPL_OFS_RESP: st_next.rdata[15:0] = st_reg.resp;
                `SPL_OFS_WINDOW: st_next.rdata[15:0] = st_reg.window;
                `SPL_OFS_FWD: st_next.rdata[15:0] = st_reg.fwd;
                `SPL_OFS_REV: st_next.rdata[15:0] = st_reg.rev;
                `SPL_OFS_STATION: st_next.rdata[15:0] = st_reg.station;
                `SPL_OFS_ENC: st_next.rdata[15:0] = st_reg.enc;
                `SPL_OFS_NUM: st_next.rdata[15:0] = st_reg.num;
                `SPL_OFS_DEN: st_next.rdata[15:0] = st_reg.den;
                `SPL_OFS_STN: st_next.rdata[15:0] = st_reg.station_count;
                `SPL_OFS_CTRL: st_next.rdata[1:0] = st_reg.ctrl;
                `SPL_OFS_STATUS: begin
                    st_next.rdata[7:0] = st_reg.fault ? `SPL_ALARM_CODE
                        : 8'h00;
                    st_next.rdata[11:8] = {st_reg.act.abs_sel,
                        st_reg.act.enc_mode, st_reg.inwin, st_reg.fault};
                end
                default: st_next.rresp = `SPL_RESP_DECERR;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_reg <= '0;
            st_reg.gain <= `SPL_RST_GAIN;
            st_reg.resp <= `SPL_RST_RESP;
            st_reg.window <= `SPL_RST_WINDOW;
            st_reg.fwd <= `SPL_RST_TORQUE;
            st_reg.rev <= `SPL_RST_TORQUE;
            st_reg.station <= `SPL_RST_STATION;
            st_reg.enc <= `SPL_RST_ENC;
            st_reg.num <= `SPL_RST_GEAR;
            st_reg.den <= `SPL_RST_GEAR;
            st_reg.station_count <= `SPL_RST_STN;
            st_reg.act.num <= `SPL_RST_GEAR;
            st_reg.act.den <= `SPL_RST_GEAR;
            st_reg.act.station_count <= `SPL_RST_STN;
            st_reg.act.enc <= `SPL_RST_ENC;
        end else begin
            st_reg <= st_next;
        end
    end

    assign enc_if.add_val = st_reg.act.enc_mode ? 32'h00000001
        : {16'h0000, st_reg.act.enc};
    assign enc_if.mod_val = st_reg.act.enc_mode
        ? {16'h0000, st_reg.act.enc} : `SPL_ENC_RES;
    assign enc_if.step = st_reg.enc_sync[1] && !st_reg.enc_sync[2]
        && !st_reg.fault;
    assign enc_if.dir = st_reg.edir_sync[1];

    spl_enc_out u_enc_out (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .enc(enc_if.gen)
    );

    assign o_s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign o_s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
    assign o_s_axi_bvalid = st_reg.bvalid;
    assign o_s_axi_bresp = st_reg.bresp;
    assign o_s_axi_arready = !st_reg.rvalid;
    assign o_s_axi_rvalid = st_reg.rvalid;
    assign o_s_axi_rdata = st_reg.rdata;
    assign o_s_axi_rresp = st_reg.rresp;
    assign o_motor_step = st_reg.mstep;
    assign o_motor_dir = st_reg.mdir;
    assign o_enc_a = enc_if.pha;
    assign o_enc_b = enc_if.phb;
    assign o_move_complete_output = st_reg.inwin;
    assign o_in_window_output = st_reg.inwin;
    assign o_torque_out = st_reg.torque;
    assign o_gain_update_mask = st_reg.gmask;
    assign o_tuning_response = st_reg.resp[5:0];
    assign o_station_order = st_reg.act.station;
    assign o_absolute_position_select = st_reg.act.abs_sel;
    assign o_parameter_fault_alarm = st_reg.fault;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    AST_GEAR_RANGE: assert property ((!st_reg.restart
        && st_reg.act.num > `SPL_GEAR_MAX) |=> o_parameter_fault_alarm)
        else $error("Numerator above range not flagged");
    AST_GEAR_RATIO: assert property ((!st_reg.restart
        && num32 * `SPL_RATIO_MAX < den32) |=> o_parameter_fault_alarm)
        else $error("Ratio below limit not flagged");
    AST_FAULT_STOPS: assert property (o_parameter_fault_alarm
        |=> !o_motor_step) else $error("Motor stepped under fault");
    AST_LATCH_RESTART: assert property (!st_reg.restart
        |=> $stable(st_reg.act)) else $error("Config changed at run");
    AST_GEAR_STEP: assert property ((!st_reg.fault
        && st_reg.acc >= den32) |=> o_motor_step)
        else $error("Due motor step missed");
    AST_GAIN_AUTO2: assert property (st_reg.gain == 16'h0002
        |=> o_gain_update_mask == 5'h1E) else $error("Bad auto two set");
    AST_WINDOW: assert property (err_abs <= {16'h0000,
        st_reg.window} |=> o_in_window_output && o_move_complete_output)
        else $error("In-window outputs missing");
    AST_FWD_CLAMP: assert property (($signed(tq_cmd) >
        $signed(tq_fwd)) |=> o_torque_out == $past(st_reg.fwd))
        else $error("Forward clamp failed");
    AST_ZERO_TORQUE: assert property ((st_reg.fwd == 16'h0000
        && st_reg.rev == 16'h0000) |=> o_torque_out == 16'h0000)
        else $error("Torque with zero clamps");

    COV_FAULT: cover property (o_parameter_fault_alarm);
    COV_IN_WINDOW: cover property (o_in_window_output);
    COV_MOTOR_STEP: cover property (o_motor_step ##1 o_motor_step);
    COV_RESTART: cover property (st_reg.restart);
endmodule

/* File: core/spl_enc_out.sv */
// Quadrature encoder pulse generator
`timescale 1ns/100ps
module spl_enc_out (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    spl_enc_if.gen enc
);
    typedef struct packed {
        logic [31:0] acc;
        logic [1:0] quad;
        logic a;
        logic b;
    } spl_enc_state_type;
    spl_enc_state_type st_reg;
    spl_enc_state_type st_next;
    logic [31:0] sum;

    always_comb begin
        st_next = st_reg;
        sum = st_reg.acc + enc.add_val;
        if (enc.step) begin
            if (sum >= enc.mod_val) begin
                st_next.acc = sum - enc.mod_val;
                st_next.quad = enc.dir ? st_reg.quad + 2'h1
                                       : st_reg.quad - 2'h1;
            end else begin
                st_next.acc = sum;
            end
        end
        st_next.a = st_next.quad[1];
        st_next.b = st_next.quad[1] ^ st_next.quad[0];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign enc.pha = st_reg.a;
    assign enc.phb = st_reg.b;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    AST_QUAD_ONE_EDGE: assert property (!($changed(st_reg.a) &&
        $changed(st_reg.b))) else $error("Both phases moved together");
    AST_ENC_STEP: assert property ((enc.step && sum >= enc.mod_val)
        |=> $changed(st_reg.quad)) else $error("Missed output edge");
endmodule

/* File: pkg/spl_enc_if.sv */
// Link between the core and the encoder pulse generator
`timescale 1ns/100ps
interface spl_enc_if;
    logic step;
    logic dir;
    logic [31:0] add_val;
    logic [31:0] mod_val;
    logic pha;
    logic phb;
    modport core (output step, dir, add_val, mod_val, input pha, phb);
    modport gen (input step, dir, add_val, mod_val, output pha, phb);
endinterface

/* File: pkg/spl_params.svh */
// Offsets, reset values, limits and codes of the servo position logic
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH
`define SPL_OFS_GAIN 8'h00
`define SPL_OFS_RESP 8'h04
`define SPL_OFS_WINDOW 8'h08
`define SPL_OFS_FWD 8'h0C
`define SPL_OFS_REV 8'h10
`define SPL_OFS_STATION 8'h14
`define SPL_OFS_ENC 8'h18
`define SPL_OFS_NUM 8'h1C
`define SPL_OFS_DEN 8'h20
`define SPL_OFS_STN 8'h24
`define SPL_OFS_CTRL 8'h28
`define SPL_OFS_STATUS 8'h2C
`define SPL_RST_GAIN 16'h0001
`define SPL_RST_RESP 16'h000C
`define SPL_RST_WINDOW 16'h0064
`define SPL_RST_TORQUE 16'h03E8
`define SPL_RST_STATION 16'h0000
`define SPL_RST_ENC 16'h0FA0
`define SPL_RST_GEAR 16'h0001
`define SPL_RST_STN 16'h0001
`define SPL_GEAR_MAX 16'h4000
`define SPL_RATIO_MAX 32'h0000270F
`define SPL_DEN_STN_MAX 32'h00007FFF
`define SPL_NUM_DEN_MAX 32'h000186A0
`define SPL_ALARM_CODE 8'h37
`define SPL_ENC_RES 32'h00040000
`define SPL_CTRL_ABS 0
`define SPL_CTRL_ENC_MODE 1
`define SPL_CTRL_RESTART 8
`define SPL_RESP_OKAY 2'h0
`define SPL_RESP_DECERR 2'h3
`endif

/* File: pkg/spl_pkg.sv */
// Types of the servo position logic
package spl_pkg;
    typedef enum logic [1:0] {
        GAIN_INTERP = 2'h0,
        GAIN_AUTO1 = 2'h1,
        GAIN_AUTO2 = 2'h2,
        GAIN_MANUAL = 2'h3
    } spl_gain_type;
    typedef struct packed {
        logic [15:0] num;
        logic [15:0] den;
        logic [15:0] station_count;
        logic [15:0] enc;
        logic station;
        logic enc_mode;
        logic abs_sel;
    } spl_cfg_type;
endpackage

/* File: test/servo_position_param_logic_test.sv */
// Testbench of the servo position parameter logic
`timescale 1ns/100ps
module servo_position_param_logic_test;
    typedef struct packed {
        logic [15:0] fwd, rev, cmd, exp;
    } spl_trow_type;
    typedef struct packed {
        logic [15:0] num, den, station_count;
        logic flt;
    } spl_grow_type;
    localparam spl_trow_type TROWS [6] = '{
        '{16'h03E8, 16'h03E8, 16'h01F4, 16'h01F4},
        '{16'h03E8, 16'h03E8, 16'h04B0, 16'h03E8},
        '{16'h012C, 16'h03E8, 16'h01F4, 16'h012C},
        '{16'h03E8, 16'h00C8, 16'hFE0C, 16'hFF38},
        '{16'h0000, 16'h03E8, 16'h0064, 16'h0000},
        '{16'h03E8, 16'h0000, 16'hFF9C, 16'h0000}};
    localparam spl_grow_type GROWS [9] = '{
        '{16'h4000, 16'h0002, 16'h0001, 1'b0},
        '{16'h4001, 16'h0002, 16'h0001, 1'b1},
        '{16'h0000, 16'h0001, 16'h0001, 1'b1},
        '{16'h0001, 16'h270F, 16'h0001, 1'b0},
        '{16'h0001, 16'h2710, 16'h0001, 1'b1},
        '{16'h0001, 16'h0002, 16'h3FFF, 1'b0},
        '{16'h0001, 16'h0002, 16'h4000, 1'b1},
        '{16'h013C, 16'h013C, 16'h0001, 1'b0},
        '{16'h013D, 16'h013C, 16'h0001, 1'b1}};
    localparam logic [4:0] MASKS [4] = '{5'h1D, 5'h1F, 5'h1E, 5'h00};
    localparam logic [31:0] ERRS [5] = '{32'h64, 32'hFFFFFF9C, 32'h65,
        32'hFFFFFF9B, 32'h0};
    localparam logic WINS [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic clk, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic cmd_pulse = 1'b0, cmd_dir = 1'b0, up_exp = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, pos_err = 32'h0, rdata, rd;
    logic [15:0] tcmd = 16'h0000, tout;
    logic awready, wready, bvalid, arready, rvalid, enc_step, enc_dir;
    logic mstep, mdir, enc_a, enc_b, done_o, win_o, st_o, abs_o, fault;
    logic a_q, b_q;
    logic [1:0] bresp, rresp, resp;
    logic [4:0] gmask;
    logic [5:0] tresp;
    int n_fail = 0, n_compared = 0, steps, edges, lead_bad;

    spl_core u_spl_core (.i_clk_sys(clk), .i_rst(rst),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(1'b1), .o_s_axi_bresp(bresp),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(1'b1), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .i_cmd_pulse(cmd_pulse),
        .i_cmd_dir(cmd_dir), .i_enc_step(enc_step), .i_enc_dir(enc_dir),
        .i_pos_err(pos_err), .i_torque_cmd(tcmd), .o_motor_step(mstep),
        .o_motor_dir(mdir), .o_enc_a(enc_a), .o_enc_b(enc_b),
        .o_move_complete_output(done_o), .o_in_window_output(win_o),
        .o_torque_out(tout), .o_gain_update_mask(gmask),
        .o_tuning_response(tresp), .o_station_order(st_o),
        .o_absolute_position_select(abs_o),
        .o_parameter_fault_alarm(fault));
    spl_motor_model u_spl_motor_model (.i_clk_sys(clk), .i_rst(rst),
        .i_step(mstep), .i_dir(mdir), .o_enc_step(enc_step),
        .o_enc_dir(enc_dir));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mstep === 1'b1) steps++;
        if (enc_a !== a_q || enc_b !== b_q) edges++;
        // B leads A when counting up
        if (enc_a === 1'b1 && a_q === 1'b0 && enc_b !== up_exp) lead_bad++;
        a_q <= enc_a;
        b_q <= enc_b;
    end

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk);
            if (!aw_d && awready === 1'b1) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_d && wready === 1'b1) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        chk($sformatf("register %h", a), e, rd);
    endtask
    task automatic cfg(input logic [31:0] c);
        wr(8'h28, c | 32'h100);
        repeat (4) @(posedge clk);
    endtask
    task automatic pulses(input int n, input logic d);
        cmd_dir <= d;
        up_exp = d;
        repeat (4) @(posedge clk);
        repeat (n) begin
            cmd_pulse <= 1'b1;
            repeat (4) @(posedge clk);
            cmd_pulse <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (80) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(8'h00, 32'h1);
        rchk(8'h04, 32'hC);
        rchk(8'h08, 32'h64);
        rchk(8'h14, 32'h0);
        rchk(8'h18, 32'hFA0);
        rchk(8'h40, 32'h0);
        chk("rresp", 32'h3, 32'(resp));
        wr(8'h40, 32'h5);
        chk("bresp", 32'h3, 32'(resp));
        $display("test reset done");
        foreach (TROWS[i]) begin
            wr(8'h0C, 32'(TROWS[i].fwd));
            wr(8'h10, 32'(TROWS[i].rev));
            tcmd <= TROWS[i].cmd;
            repeat (3) @(posedge clk);
            chk("torque", 32'(TROWS[i].exp), 32'(tout));
        end
        for (int g = 0; g < 4; g++) begin
            wr(8'h00, 32'(g));
            repeat (2) @(posedge clk);
            chk("gain mask", 32'(MASKS[g]), 32'(gmask));
        end
        wr(8'h04, 32'h20);
        repeat (2) @(posedge clk);
        chk("response", 32'h20, 32'(tresp));
        foreach (ERRS[i]) begin
            pos_err <= ERRS[i];
            repeat (3) @(posedge clk);
            chk("complete", 32'(WINS[i]), 32'(done_o));
            chk("in window", 32'(WINS[i]), 32'(win_o));
        end
        $display("test settings done");
        wr(8'h14, 32'h1);
        wr(8'h1C, 32'h190);
        wr(8'h20, 32'h12C);
        repeat (3) @(posedge clk);
        chk("fault", 32'h0, 32'(fault));
        chk("station", 32'h0, 32'(st_o));
        cfg(32'h1);
        chk("fault", 32'h1, 32'(fault));
        chk("station", 32'h1, 32'(st_o));
        chk("abs", 32'h1, 32'(abs_o));
        rchk(8'h2C, 32'hB37);
        foreach (GROWS[i]) begin
            wr(8'h1C, 32'(GROWS[i].num));
            wr(8'h20, 32'(GROWS[i].den));
            wr(8'h24, 32'(GROWS[i].station_count));
            cfg(32'h1);
            chk("gear fault", 32'(GROWS[i].flt), 32'(fault));
        end
        $display("test restart done");
        wr(8'h24, 32'h1);
        wr(8'h1C, 32'h1);
        wr(8'h20, 32'h1);
        wr(8'h18, 32'h8);
        cfg(32'h2);
        chk("fault", 32'h0, 32'(fault));
        edges = 0;
        lead_bad = 0;
        pulses(64, 1'b1);
        chk("edges up", 32'h8, 32'(edges));
        chk("motor dir up", 32'h1, 32'(mdir));
        edges = 0;
        pulses(64, 1'b0);
        chk("edges down", 32'h8, 32'(edges));
        chk("motor dir down", 32'h0, 32'(mdir));
        chk("phase lead", 32'h0, 32'(lead_bad));
        wr(8'h18, 32'h8000);
        cfg(32'h0);
        edges = 0;
        pulses(64, 1'b1);
        chk("edges mode 0", 32'h8, 32'(edges));
        wr(8'h1C, 32'h32);
        wr(8'h20, 32'h14);
        cfg(32'h0);
        steps = 0;
        pulses(4, 1'b1);
        chk("motor steps", 32'hA, 32'(steps));
        $display("test motion done");
        print_verdict();
    end
endmodule

/* File: test/spl_motor_model.sv */
// Servo motor with encoder: one encoder count per motor step
`timescale 1ns/100ps
module spl_motor_model #(
    parameter int HIGH_CYC = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_step,
    input wire logic i_dir,
    output logic o_enc_step,
    output logic o_enc_dir
);
    int pending;
    int cnt;
    logic start;
    assign start = (cnt == 0) && (pending > 0);
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            pending <= 0;
            cnt <= 0;
            o_enc_step <= 1'b0;
            o_enc_dir <= 1'b0;
        end else begin
            pending <= pending + int'(i_step) - int'(start);
            cnt <= start ? 2 * HIGH_CYC : (cnt > 0 ? cnt - 1 : 0);
            o_enc_step <= start || (cnt > HIGH_CYC + 1);
            if (start) begin
                o_enc_dir <= i_dir;
            end
        end
    end
endmodule
